//--- include/sro_defines.vh
// Constants for the converter result output port
`ifndef SRO_DEFINES_VH
`define SRO_DEFINES_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define SRO_CLK_MHZ          250
`define SRO_ACQ_TIME_NS      500
`define SRO_ACQ_CYCLES       ((`SRO_ACQ_TIME_NS * `SRO_CLK_MHZ + 999) / 1000)
`define SRO_CONV_TIME_NS     1250
`define SRO_CONV_CYCLES      ((`SRO_CONV_TIME_NS * `SRO_CLK_MHZ + 999) / 1000)
`define SRO_SCLK_QTR_NS      12
`define SRO_SCLK_QTR_CYCLES  ((`SRO_SCLK_QTR_NS * `SRO_CLK_MHZ + 999) / 1000)
`define SRO_ERR_PULSE_CYCLES 4

// ----------------------------------------------------------------
// Modes and frame layout
// ----------------------------------------------------------------
`define SRO_MODE_SERIAL      2'h3
`define SRO_RESULT_BITS      18
`define SRO_FRAME_LAST_BIT   5'h11
`define SRO_CHAIN_DELAY      5'h12
`define SRO_RESULT_RESET     18'h00000

`endif

//--- design/sro_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sro_sync3 #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire sys_clk_in,
    input  wire rst_n_in,
    // Asynchronous level in, filtered level out
    input  wire async_in,
    output reg  level_out
);
    reg stage1;
    reg stage2;
    reg stage3;

    // First stage feeds only the second; level moves once stages two and three agree
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            stage1    <= RESET_VAL;
            stage2    <= RESET_VAL;
            stage3    <= RESET_VAL;
            level_out <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end
endmodule

//--- design/sro_result_port.v
// Conversion control and parallel/serial result output port
`timescale 1ns/1ps
`include "sro_defines.vh"
module sro_result_port (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // Device control pins
    input  wire        device_reset_in,
    input  wire        power_down_in,
    input  wire        conversion_start_n_in,
    input  wire        chip_select_n_in,
    input  wire        read_n_in,
    // Configuration pins
    input  wire [1:0]  mode_in,
    input  wire        output_format_select_in,
    input  wire        clock_source_select_in,
    input  wire        clock_edge_invert_in,
    input  wire        frame_sync_polarity_in,
    input  wire        read_mode_or_chain_in,
    input  wire        sclk_in,
    // Converter core
    input  wire [17:0] sample_code_in,
    // Outputs
    output reg         busy_out,
    output reg         sample_hold_out,
    output reg  [17:0] data_out,
    output reg  [17:0] data_oe_out
);
    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    localparam integer ACQ_LAST  = `SRO_ACQ_CYCLES - 1;
    localparam integer CONV_LAST = `SRO_CONV_CYCLES - 1;
    localparam integer QTR_LAST  = `SRO_SCLK_QTR_CYCLES - 1;
    localparam integer ERR_LEN   = `SRO_ERR_PULSE_CYCLES;

    localparam [1:0] ST_ACQ  = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    wire rst_s;
    wire pd_s;
    wire conversion_start_n_s;
    wire cs_n_s;
    wire rd_n_s;
    wire sclk_s;
    wire chain_s;

    sro_sync3 #(.RESET_VAL(1'b0)) u_sync_rst (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (device_reset_in),
        .level_out  (rst_s)
    );
    sro_sync3 #(.RESET_VAL(1'b0)) u_sync_pd (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (power_down_in),
        .level_out  (pd_s)
    );
    sro_sync3 #(.RESET_VAL(1'b1)) u_sync_conversion_start_n (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (conversion_start_n_in),
        .level_out  (conversion_start_n_s)
    );
    sro_sync3 #(.RESET_VAL(1'b1)) u_sync_cs (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (chip_select_n_in),
        .level_out  (cs_n_s)
    );
    sro_sync3 #(.RESET_VAL(1'b1)) u_sync_rd (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (read_n_in),
        .level_out  (rd_n_s)
    );
    sro_sync3 #(.RESET_VAL(1'b0)) u_sync_sclk (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (sclk_in),
        .level_out  (sclk_s)
    );
    sro_sync3 #(.RESET_VAL(1'b0)) u_sync_chain (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   (read_mode_or_chain_in),
        .level_out  (chain_s)
    );

    // ----------------------------------------------------------------
    // Conversion control
    // ----------------------------------------------------------------
    reg  [1:0]  state;
    reg  [8:0]  cnt;
    reg         conversion_start_n_prev;
    reg         conv_done;
    reg  [17:0] result;
    wire        soft_rst = !rst_n_in || rst_s;
    // Core delivers offset binary; two's complement only flips the MSB
    wire [17:0] coded = {sample_code_in[17] ^ ~output_format_select_in,
                         sample_code_in[16:0]};

    always @(posedge sys_clk_in) begin
        if (soft_rst) begin
            state      <= ST_ACQ;
            cnt        <= 9'h000;
            conversion_start_n_prev <= 1'b1;
            conv_done  <= 1'b0;
            busy_out   <= 1'b0;
            result     <= `SRO_RESULT_RESET;
        end else begin
            conversion_start_n_prev <= conversion_start_n_s;
            conv_done  <= 1'b0;
            case (state)
                ST_ACQ: begin
                    if (cnt == ACQ_LAST[8:0]) begin
                        cnt <= 9'h000;
                        if (!pd_s && !conversion_start_n_s) begin
                            state    <= ST_CONV;
                            busy_out <= 1'b1;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end else begin
                        cnt <= cnt + 9'h001;
                    end
                end
                ST_WAIT: begin
                    if (!pd_s && conversion_start_n_prev && !conversion_start_n_s) begin
                        state    <= ST_CONV;
                        busy_out <= 1'b1;
                    end
                end
                ST_CONV: begin
                    // Power down is not checked here so a running conversion completes
                    if (cnt == CONV_LAST[8:0]) begin
                        cnt       <= 9'h000;
                        result    <= coded;
                        busy_out  <= 1'b0;
                        conv_done <= 1'b1;
                        state     <= ST_ACQ;
                    end else begin
                        cnt <= cnt + 9'h001;
                    end
                end
                default: begin
                    state <= ST_ACQ;
                    cnt   <= 9'h000;
                end
            endcase
        end
    end

    always @(posedge sys_clk_in) begin
        if (soft_rst) begin
            sample_hold_out <= 1'b0;
        end else begin
            sample_hold_out <= (state == ST_CONV);
        end
    end

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    reg         frame;
    reg         fresh;
    reg  [17:0] shreg;
    reg  [4:0]  bitcnt;
    reg  [1:0]  qphase;
    reg  [3:0]  qcnt;
    reg         sclk_int;
    reg         serial_data;
    reg         sclk_prev;
    reg  [2:0]  err_cnt;
    wire        serial   = (mode_in == `SRO_MODE_SERIAL);
    wire        ext      = clock_source_select_in;
    wire        out_en   = !cs_n_s && !rd_n_s;
    wire        sclk_rise = !cs_n_s && sclk_s && !sclk_prev;
    wire        sclk_fall = !cs_n_s && !sclk_s && sclk_prev;
    wire        upd_edge = clock_edge_invert_in ? sclk_fall : sclk_rise;
    wire        qtick    = (qcnt == QTR_LAST[3:0]);
    wire        rd_phase = read_mode_or_chain_in ? busy_out : !busy_out;
    wire        start_m  = serial && !ext && out_en && fresh && !frame && rd_phase;
    wire        start_s  = serial && ext && out_en && fresh && !frame;
    wire        rd_abort = conv_done && frame && ext && (bitcnt < `SRO_CHAIN_DELAY);

    always @(posedge sys_clk_in) begin
        if (soft_rst) begin
            frame       <= 1'b0;
            fresh       <= 1'b0;
            shreg       <= `SRO_RESULT_RESET;
            bitcnt      <= 5'h00;
            qphase      <= 2'h0;
            qcnt        <= 4'h0;
            sclk_int    <= 1'b0;
            serial_data <= 1'b0;
            sclk_prev   <= 1'b0;
            err_cnt     <= 3'h0;
        end else begin
            sclk_prev <= sclk_s;
            // A new result wins over a read that consumes the old one
            if (conv_done) begin
                fresh <= 1'b1;
            end else if (start_m || start_s) begin
                fresh <= 1'b0;
            end
            if (err_cnt != 3'h0) begin
                err_cnt <= err_cnt - 3'h1;
            end
            if (rd_abort) begin
                frame   <= 1'b0;
                err_cnt <= ERR_LEN[2:0];
            end else if (start_m || start_s) begin
                frame       <= 1'b1;
                shreg       <= result;
                serial_data <= result[17];
                bitcnt      <= 5'h00;
                qphase      <= 2'h0;
                qcnt        <= 4'h0;
                sclk_int    <= 1'b0;
            end else if (frame && !ext) begin
                // Data moves a quarter period before the rising edge
                qcnt <= qtick ? 4'h0 : qcnt + 4'h1;
                if (qtick) begin
                    qphase <= qphase + 2'h1;
                    if (qphase == 2'h0) begin
                        sclk_int <= 1'b1;
                    end
                    if (qphase == 2'h2) begin
                        sclk_int <= 1'b0;
                    end
                    if (qphase == 2'h3) begin
                        if (bitcnt == `SRO_FRAME_LAST_BIT) begin
                            frame <= 1'b0;
                        end else begin
                            bitcnt      <= bitcnt + 5'h01;
                            shreg       <= {shreg[16:0], 1'b0};
                            serial_data <= shreg[16];
                        end
                    end
                end
            end else if (serial && ext && upd_edge) begin
                // Chain bits enter behind the result and appear eighteen edges on
                shreg       <= {shreg[16:0], chain_s};
                serial_data <= shreg[16];
                if (bitcnt < `SRO_CHAIN_DELAY) begin
                    bitcnt <= bitcnt + 5'h01;
                end
                if (bitcnt == `SRO_FRAME_LAST_BIT) begin
                    frame <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin multiplexing
    // ----------------------------------------------------------------
    wire clock_source_select = ext;
    wire frame_sync          = (frame && !ext) ^ frame_sync_polarity_in;
    wire serial_clk          = sclk_int ^ clock_edge_invert_in;
    wire incomplete_read_flag = (err_cnt != 3'h0) && ext;

    always @(posedge sys_clk_in) begin
        if (soft_rst) begin
            data_out    <= 18'h00000;
            data_oe_out <= 18'h00000;
        end else if (!serial) begin
            data_out    <= result;
            data_oe_out <= {18{out_en}};
        end else begin
            data_out    <= {result[17:14], incomplete_read_flag, frame_sync,
                            serial_clk, serial_data, 10'h000};
            data_oe_out <= {{4{out_en}}, 2'h3, !clock_source_select, out_en,
                            10'h000};
        end
    end
endmodule

//--- verif/sro_host_model.sv
// Host side model that clocks and captures the external serial port
`timescale 1ns/1ps
module sro_host_model #(
    parameter HALF_NS = 40
) (
    // Pin level and edge choice
    input  wire        inv_in,
    input  wire        serial_in,
    // Serial clock and captured bits
    output wire        sclk_out,
    output reg  [35:0] capture_out
);
    reg ph = 1'b0;
    // Clock stands still between frames; invert only moves the update edge
    assign sclk_out = ph ^ inv_in;
    task run(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                #(HALF_NS) capture_out = {capture_out[34:0], serial_in};
                ph = 1'b1;
                #(HALF_NS) ph = 1'b0;
            end
        end
    endtask
endmodule

//--- verif/sro_result_port_sva.sv
// Assertion checker for the result output port
`timescale 1ns/1ps
module sro_port_sva (
    // Clock and reset
    input wire        sys_clk_in,
    input wire        rst_n_in,
    // Control pins
    input wire        device_reset_in,
    input wire        power_down_in,
    input wire        chip_select_n_in,
    input wire        read_n_in,
    input wire [1:0]  mode_in,
    input wire        clock_source_select_in,
    input wire        frame_sync_polarity_in,
    // Outputs
    input wire        busy_out,
    input wire        sample_hold_out,
    input wire [17:0] data_out,
    input wire [17:0] data_oe_out
);
    reg  [8:0] bcnt;
    reg  [7:0] drh;
    reg  [2:0] lv = 3'h0;
    reg  [4:0] rc;
    reg        pp;
    wire       fa = mode_in == 2'h3 && data_oe_out[11] && data_out[12] != pp;
    // Settle window after any reset so stale outputs are not judged
    always @(posedge sys_clk_in) begin
        bcnt <= busy_out ? bcnt + 9'h1 : 9'h0;
        drh  <= {drh[6:0], device_reset_in};
        lv   <= {lv[1:0], rst_n_in && drh == 8'h00};
        pp   <= frame_sync_polarity_in;
        rc   <= fa ? rc + {4'h0, $rose(data_out[11])} : 5'h00;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (lv != 3'h7);
    property p_busy_len; $fell(busy_out) |-> bcnt == 9'h139; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy width wrong");
    property p_hold; $rose(busy_out) |=> $rose(sample_hold_out); endproperty
    a_hold: assert property (p_hold) else $error("hold not after busy");
    property p_abort; disable iff (!rst_n_in)
        device_reset_in [*8] |-> !busy_out && data_oe_out == 18'h00000; endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");
    property p_par; (!chip_select_n_in && !read_n_in && mode_in != 2'h3) [*8]
        |-> data_oe_out == 18'h3ffff; endproperty
    a_par: assert property (p_par) else $error("parallel drivers off");
    property p_top; (!chip_select_n_in && !read_n_in) [*8] |-> data_oe_out[17:14] == 4'hf;
    endproperty
    a_top: assert property (p_top) else $error("top bits not driven");
    property p_off; chip_select_n_in [*8] |-> data_oe_out[17:14] == 4'h0 && !data_oe_out[10];
    endproperty
    a_off: assert property (p_off) else $error("drivers on while deselected");
    property p_dir; mode_in == 2'h3 |=> data_oe_out[11] == !$past(clock_source_select_in);
    endproperty
    a_dir: assert property (p_dir) else $error("serial clock direction wrong");
    property p_frame; $fell(fa) |-> rc == 5'h12; endproperty
    a_frame: assert property (p_frame) else $error("frame bit count wrong");
    property p_pd; power_down_in [*8] |-> !$rose(busy_out); endproperty
    a_pd: assert property (p_pd) else $error("start during power down");
    property p_flag; mode_in == 2'h3 && !data_oe_out[11] && $rose(data_out[13])
        |-> data_out[13] [*4] ##1 !data_out[13]; endproperty
    a_flag: assert property (p_flag) else $error("error pulse width wrong");
endmodule
bind sro_result_port sro_port_sva u_sva (
    .sys_clk_in             (sys_clk_in),
    .rst_n_in               (rst_n_in),
    .device_reset_in        (device_reset_in),
    .power_down_in          (power_down_in),
    .chip_select_n_in       (chip_select_n_in),
    .read_n_in              (read_n_in),
    .mode_in                (mode_in),
    .clock_source_select_in (clock_source_select_in),
    .frame_sync_polarity_in (frame_sync_polarity_in),
    .busy_out               (busy_out),
    .sample_hold_out        (sample_hold_out),
    .data_out               (data_out),
    .data_oe_out            (data_oe_out)
);

//--- verif/tb_top.sv
// Self-checking testbench for the result output port
`timescale 1ns/1ps
module tb_top;
    reg         clk = 1'b0, rstn = 1'b0, drst = 1'b0, pd = 1'b0, stn = 1'b1;
    reg         csn = 1'b1, rdn = 1'b1, fmt = 1'b1, src = 1'b0, inv = 1'b0;
    reg         fsp = 1'b0, rdc = 1'b0;
    reg  [1:0]  mode = 2'h0;
    reg  [17:0] code = 18'h00000, prev;
    wire        busy, sclk;
    wire [17:0] dout, doe;
    wire [35:0] cap;
    integer     error_cnt = 0, n_compared = 0, seed = 32'h7dcef818, k, j;
    always #2 clk = ~clk;
    sro_result_port dut (.sys_clk_in(clk), .rst_n_in(rstn), .device_reset_in(drst),
        .power_down_in(pd), .conversion_start_n_in(stn), .chip_select_n_in(csn),
        .read_n_in(rdn), .mode_in(mode), .output_format_select_in(fmt),
        .clock_source_select_in(src), .clock_edge_invert_in(inv),
        .frame_sync_polarity_in(fsp), .read_mode_or_chain_in(rdc), .sclk_in(sclk),
        .sample_code_in(code), .busy_out(busy), .sample_hold_out(), .data_out(dout),
        .data_oe_out(doe));
    // A released data pin shows the inverse so a capture while chip select or read is high cannot pass
    sro_host_model hst (.inv_in(inv), .serial_in(doe[10] ? dout[10] : ~dout[10]),
        .sclk_out(sclk), .capture_out(cap));
    // ----
    // Helpers
    // ----
    function [17:0] expv(input [17:0] c, input f);
        expv = f ? c : c ^ 18'h20000;
    endfunction
    task chk(input [35:0] s, input [35:0] e);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
            end
        end
    endtask
    task close_out;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    // Start held low until busy, so it is taken at the end of acquisition or, once that is over, on its falling edge
    task conv(input [17:0] c);
        integer i;
        begin
            code = c;
            stn = 1'b0;
            for (i = 0; i < 300 && busy !== 1'b1; i = i + 1) @(negedge clk);
            stn = 1'b1;
            for (i = 0; i < 400 && busy !== 1'b0; i = i + 1) @(negedge clk);
            chk(i, 36'h139);
        end
    endtask
    task ifr(input [17:0] e);
        reg [17:0] b;
        reg        p;
        integer    n, i;
        begin
            n = 0;
            p = 1'b0;
            for (i = 0; i < 700 && !(n == 18 && dout[12] === fsp); i = i + 1) begin
                @(negedge clk);
                // Capture on the internal clock's first edge, recheck on its second
                if (dout[12] !== fsp && (dout[11] ^ inv) && !p) begin
                    b = {b[16:0], dout[10]};
                    n = n + 1;
                end
                if (dout[12] !== fsp && !(dout[11] ^ inv) && p) chk(dout[10], b[0]);
                p = dout[11] ^ inv;
            end
            chk(n, 36'h12);
            chk(b, e);
        end
    endtask
    // ----
    // Tests
    // ----
    initial begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        for (k = 0; k < 4; k = k + 1) begin
            mode = (k == 3) ? 2'h0 : k[1:0];
            j = $random(seed);
            fmt = j[20];
            conv(k == 0 ? 18'h00000 : k == 1 ? 18'h3ffff : j[17:0]);
            {csn, rdn} = 2'h0;
            repeat (10) @(negedge clk);
            chk(dout, expv(code, fmt));
            chk(doe, 36'h3ffff);
            {csn, rdn} = k[0] ? 2'h1 : 2'h2;
            repeat (10) @(negedge clk);
            chk(doe, 36'h0);
        end
        $display("parallel test done");
        {mode, src, csn, rdn} = 5'h1f;
        for (k = 0; k < 2; k = k + 1) begin
            inv = k[0];
            j = $random(seed);
            rdc = j[20];
            conv(j[17:0]);
            hst.run(5);
            {csn, rdn} = 2'h0;
            prev = expv(code, fmt);
            hst.run(36);
            chk(cap, {prev, {18{rdc}}});
            chk({doe[11], dout[17:14]}, {1'b0, prev[17:14]});
            {csn, rdn} = 2'h3;
        end
        conv(18'h15a5a);
        {csn, rdn} = 2'h0;
        hst.run(5);
        j = 0;
        fork
            conv(18'h2a5a5);
            repeat (500) begin
                @(negedge clk);
                if (dout[13] === 1'b1) j = j + 1;
            end
        join
        chk(j, 36'h4);
        {csn, rdn, src, rdc} = 4'hc;
        $display("external clock test done");
        for (k = 0; k < 2; k = k + 1) begin
            fsp = k[0];
            j = $random(seed);
            conv(j[17:0]);
            {csn, rdn} = 2'h0;
            ifr(expv(code, fmt));
            {csn, rdn} = 2'h3;
        end
        conv(18'h0f0f0);
        prev = expv(code, fmt);
        {csn, rdn, rdc} = 3'h1;
        fork
            conv(18'h30303);
            ifr(prev);
        join
        {csn, rdn, rdc} = 3'h6;
        $display("internal clock test done");
        fork
            conv(18'h12345);
            begin
                wait (busy === 1'b1);
                repeat (20) @(negedge clk);
                pd = 1'b1;
            end
        join
        stn = 1'b0;
        j = 0;
        repeat (400) begin
            @(negedge clk);
            if (busy !== 1'b0) j = 1;
        end
        chk(j, 36'h0);
        {stn, pd} = 2'h2;
        repeat (2) @(negedge clk);
        stn = 1'b0;
        for (j = 0; j < 300 && busy !== 1'b1; j = j + 1) @(negedge clk);
        chk(busy, 36'h1);
        repeat (50) @(negedge clk);
        drst = 1'b1;
        repeat (10) @(negedge clk);
        chk({busy, doe}, 36'h0);
        {drst, stn} = 2'h1;
        repeat (2) @(negedge clk);
        conv(18'h2aaaa);
        $display("power and reset test done");
        close_out;
    end
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        close_out;
    end
endmodule
